// ---- rsl_regs.vh ----
// constants for the scan, lockout and display controller
// assumes one 250 MHz clock and a plain register port with word offsets
//
// Notes on behaviour
// - search on busy key-up steps scan order, keys first carrier-free channel
// - search skips locked-out channels without testing their carrier
// - with search on, off-hook keeps scanning and coded squelch; monitor works
// - lockout press toggles displayed channel bit; skip marker only when set
// - locked channel flashes skip marker when it first appears on display
// - selected channel is always scanned, locked or not
// - lockout press may clear dealer-set lockout bits
// - priority channels are scanned even when locked out
// - a lockout that would lock every channel is refused
// - in scan, presses only set bits, and only while listening
// - locking the heard channel mutes at once; scan resumes unless selected
// - option keeps lockout over power-off, else power-up leaves dealer bits
// - 20 channels standard, 99 with expansion, shown as two digits
// - power-up restores the last selected channel
// - lockout and priority status flash on channel change, scan exit, power-up
// - priority markers shown only for dealer-fixed priority channels
// - scan, lockout, auxiliary presses flash their mode glyph
// - synth unlock flashes display and beeps; in transmit disables transmitter
// - receive with synth unlocked reloads synth once each second
// - time-out flashes channel, alternating tone, transmitter off; release clears
// - key-up on receive-only channel: transmitter off, flash, beep
// - busy lockout: key-up with carrier keeps transmitter off, flash, beep
`ifndef RSL_REGS_VH
`define RSL_REGS_VH
`define RSL_A_CTRL 8'h00
`define RSL_A_CMD 8'h04
`define RSL_A_SAVED 8'h08
`define RSL_A_STAT 8'h0c
`define RSL_A_TOUT 8'h10
`define RSL_A_PRIO 8'h14
`define RSL_G_DLK 4'h2
`define RSL_G_RXO 4'h3
`define RSL_G_LK 4'h4
`define RSL_B_OPEN 0
`define RSL_B_BUSY 1
`define RSL_B_RETAIN 2
`define RSL_B_EXP 3
`define RSL_B_PFIX 4
`define RSL_B_STOPHOOK 5
`define RSL_CTRL_RST 8'h00
`define RSL_TOUT_RST 16'h0258
`define RSL_PRIO_RST 16'h7f7f
`define RSL_CH_STD 7'h14
`define RSL_CH_EXP 7'h63
`define RSL_CLK_HZ 250000000
`define RSL_TICK_MS 100
`define RSL_RELOAD_MS 1000
`define RSL_FLASH_MS 1000
`define RSL_ALT_MS 200
`define RSL_F_LO_HZ 800
`define RSL_F_HI_HZ 1000
`define RSL_GL_NONE 3'h0
`define RSL_GL_SKIP 3'h1
`define RSL_GL_FIRST 3'h2
`define RSL_GL_SECOND 3'h3
`define RSL_GL_ACC 3'h4
`define RSL_GL_SCAN 3'h5
`endif

// ---- rsl_ctrl.v ----
// scan, lockout search, channel display and error tone controller
// assumes debounced active-high switch levels from pins, synchronised here
`include "rsl_regs.vh"
module rsl_ctrl #(
  parameter TICK_CYC = `RSL_CLK_HZ / 1000 * `RSL_TICK_MS,
  parameter LO_HALF = `RSL_CLK_HZ / (2 * `RSL_F_LO_HZ),
  parameter HI_HALF = `RSL_CLK_HZ / (2 * `RSL_F_HI_HZ)
) (
  input wire mclk,
  input wire resetn,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata_r,
  input wire ptt_in,
  input wire hook_off_in,
  input wire carrier_in,
  input wire synth_lock_in,
  input wire scan_sw_in,
  input wire lockout_sw_in,
  input wire aux_sw_in,
  input wire chan_step_in,
  input wire monitor_sw_in,
  output reg tx_en_r,
  output reg tone_out_r,
  output reg [3:0] disp_tens_r,
  output reg [3:0] disp_ones_r,
  output reg [2:0] disp_glyph_r,
  output reg disp_on_r,
  output reg synth_reload_r,
  output reg [6:0] tune_chan_r,
  output reg audio_mute_r,
  output reg coded_sq_defeat_r,
  output reg aux_pwr_r,
  output reg scan_active_r
);
  localparam RELOAD_TICKS = 4'd10;
  localparam FLASH_TICKS = 4'd10;
  localparam ALT_TICKS = 4'd2;
  localparam ST_IDLE = 5'b00001;
  localparam ST_SRCH = 5'b00010;
  localparam ST_TX = 5'b00100;
  localparam ST_BLK = 5'b01000;
  localparam ST_TOUT = 5'b10000;
  localparam I_PTT = 8, I_HOOK = 7, I_CAR = 6, I_LOCK = 5, I_SCAN = 4, I_LKSW = 3, I_AUX = 2, I_STEP = 1, I_MON = 0;

  // pin inputs: two flops, then one more for edge detect
  reg [8:0] s1_r, s2_r, s3_r;
  wire [8:0] raw = {ptt_in, hook_off_in, carrier_in, synth_lock_in, scan_sw_in,
                    lockout_sw_in, aux_sw_in, chan_step_in, monitor_sw_in};
  wire [8:0] rise = s2_r & ~s3_r;
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      // lock idles high, so no false unlock right after reset
      s1_r <= 9'h020;
      s2_r <= 9'h020;
      s3_r <= 9'h020;
    end else begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  wire carrier = s2_r[I_CAR];
  wire locked = s2_r[I_LOCK];

  // software registers
  reg [7:0] ctrl_r;
  reg [6:0] saved_r;
  reg [15:0] tout_r;
  reg [15:0] prio_r;
  reg [127:0] dlk_r, rxo_r, lk_r;
  reg pwr_up_r;
  wire [6:0] p1 = prio_r[6:0];
  wire [6:0] p2 = prio_r[14:8];
  wire open_en = ctrl_r[`RSL_B_OPEN];
  wire [6:0] nch = ctrl_r[`RSL_B_EXP] ? `RSL_CH_EXP : `RSL_CH_STD;
  wire [1:0] wsel = reg_addr[3:2];
  wire wr_lk = reg_wr && reg_addr[7:4] == `RSL_G_LK;
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= `RSL_CTRL_RST;
      saved_r <= 7'h00;
      tout_r <= `RSL_TOUT_RST;
      prio_r <= `RSL_PRIO_RST;
      dlk_r <= 128'h0;
      rxo_r <= 128'h0;
      pwr_up_r <= 1'b0;
    end else begin
      pwr_up_r <= reg_wr && reg_addr == `RSL_A_CMD && reg_wdata[0];
      if (reg_wr) begin
        case (reg_addr)
          `RSL_A_CTRL: ctrl_r <= reg_wdata[7:0];
          `RSL_A_SAVED: saved_r <= reg_wdata[6:0];
          `RSL_A_TOUT: tout_r <= reg_wdata[15:0];
          `RSL_A_PRIO: prio_r <= reg_wdata[15:0];
          default: begin
            if (reg_addr[7:4] == `RSL_G_DLK)
              dlk_r[32*wsel +: 32] <= reg_wdata;
            if (reg_addr[7:4] == `RSL_G_RXO)
              rxo_r[32*wsel +: 32] <= reg_wdata;
          end
        endcase
      end
    end
  end

  // 100 ms time base shared by all slow timers
  reg [31:0] tick_cnt_r;
  reg tick_r;
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tick_cnt_r <= 32'h0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= tick_cnt_r == TICK_CYC - 1;
      tick_cnt_r <= (tick_cnt_r == TICK_CYC - 1) ? 32'h0 : tick_cnt_r + 32'h1;
    end
  end

  reg [6:0] sel_r, scan_ch_r, tx_ch_r, steps_r;
  reg scan_on_r, listen_r, hold_r;
  reg [4:0] st_r;

  // priority channels and the selected one stay in the sequence
  function elig;
    input [6:0] t;
    begin
      elig = t < nch && (!lk_r[t] || t == sel_r || t == p1 || t == p2);
    end
  endfunction

  function [6:0] nxt;
    input [6:0] c;
    integer k;
    reg [6:0] t;
    reg f;
    begin
      nxt = c;
      f = 1'b0;
      t = c;
      for (k = 0; k < 99; k = k + 1) begin
        t = (t + 7'd1 >= nch) ? 7'h00 : t + 7'd1;
        if (!f && elig(t)) begin
          nxt = t;
          f = 1'b1;
        end
      end
    end
  endfunction

  function [6:0] free_cnt;
    input [127:0] v;
    integer i;
    begin
      free_cnt = 7'h00;
      for (i = 0; i < 99; i = i + 1)
        if (i < nch && !v[i])
          free_cnt = free_cnt + 7'd1;
    end
  endfunction

  wire can_lock = free_cnt(lk_r) > 7'd1;
  wire hook_halt = s2_r[I_HOOK] && ctrl_r[`RSL_B_STOPHOOK] && !open_en;
  wire rx = st_r == ST_IDLE;
  wire [6:0] shown = (listen_r && scan_on_r) ? scan_ch_r : (rx ? sel_r : tx_ch_r);

  // channel selection, scan and lockout bits
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sel_r <= 7'h00;
      scan_ch_r <= 7'h00;
      scan_on_r <= 1'b0;
      listen_r <= 1'b0;
      hold_r <= 1'b0;
      lk_r <= 128'h0;
    end else begin
      if (wr_lk)
        lk_r[32*wsel +: 32] <= reg_wdata;
      if (pwr_up_r) begin
        sel_r <= saved_r < nch ? saved_r : 7'h00;
        scan_ch_r <= saved_r < nch ? saved_r : 7'h00;
        if (!ctrl_r[`RSL_B_RETAIN])
          lk_r <= dlk_r;
      end else if (rx) begin
        if (rise[I_STEP]) begin
          sel_r <= (sel_r + 7'd1 >= nch) ? 7'h00 : sel_r + 7'd1;
          scan_ch_r <= (sel_r + 7'd1 >= nch) ? 7'h00 : sel_r + 7'd1;
        end
        if (rise[I_SCAN]) begin
          scan_on_r <= !scan_on_r;
          scan_ch_r <= sel_r;
          listen_r <= 1'b0;
        end
        if (!carrier)
          hold_r <= 1'b0;
        if (scan_on_r && rise[I_LKSW]) begin
          // in scan only the channel being heard can be locked
          if (listen_r && !lk_r[scan_ch_r] && can_lock) begin
            lk_r[scan_ch_r] <= 1'b1;
            hold_r <= 1'b1;
            if (scan_ch_r != sel_r) begin
              listen_r <= 1'b0;
              scan_ch_r <= nxt(scan_ch_r);
            end
          end
        end else if (rise[I_LKSW]) begin
          if (lk_r[sel_r])
            lk_r[sel_r] <= 1'b0;
          else if (can_lock)
            lk_r[sel_r] <= 1'b1;
        end else if (scan_on_r && tick_r && !hook_halt) begin
          if (listen_r && !carrier)
            listen_r <= 1'b0;
          else if (!listen_r && carrier && !hold_r)
            listen_r <= 1'b1;
          else if (!listen_r)
            scan_ch_r <= nxt(scan_ch_r);
        end
      end
    end
  end

  // key-up sequencing: open-channel search, busy and receive-only checks
  reg [15:0] tout_cnt_r;
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_r <= ST_IDLE;
      tx_ch_r <= 7'h00;
      steps_r <= 7'h00;
      tout_cnt_r <= 16'h0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          tout_cnt_r <= 16'h0;
          steps_r <= 7'h00;
          tx_ch_r <= sel_r;
          if (rise[I_PTT])
            st_r <= rxo_r[sel_r] ? ST_BLK : ST_SRCH;
        end
        ST_SRCH: begin
          // one tick of settling before carrier is trusted
          if (!s2_r[I_PTT])
            st_r <= ST_IDLE;
          else if (tick_r) begin
            if (!carrier)
              st_r <= rxo_r[tx_ch_r] ? ST_BLK : ST_TX;
            else if (open_en) begin
              if (steps_r >= nch)
                st_r <= ST_BLK;
              else begin
                tx_ch_r <= nxt(tx_ch_r);
                steps_r <= steps_r + 7'd1;
              end
            end else if (ctrl_r[`RSL_B_BUSY])
              st_r <= ST_BLK;
            else
              st_r <= ST_TX;
          end
        end
        ST_TX: begin
          if (!s2_r[I_PTT])
            st_r <= ST_IDLE;
          else if (tick_r) begin
            tout_cnt_r <= tout_cnt_r + 16'h1;
            if (tout_cnt_r + 16'h1 >= tout_r)
              st_r <= ST_TOUT;
          end
        end
        ST_BLK, ST_TOUT: begin
          // a retry needs a fresh press, holding never gets through
          if (!s2_r[I_PTT])
            st_r <= ST_IDLE;
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // tones, flashing and synth reload
  reg [31:0] half_cnt_r;
  reg [3:0] alt_cnt_r, rl_cnt_r;
  reg alt_hi_r, blink_r;
  wire beep = st_r == ST_BLK || !locked;
  wire alt = st_r == ST_TOUT;
  wire [31:0] half = alt_hi_r ? HI_HALF : LO_HALF;
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      half_cnt_r <= 32'h0;
      alt_cnt_r <= 4'h0;
      rl_cnt_r <= 4'h0;
      alt_hi_r <= 1'b0;
      blink_r <= 1'b0;
      tone_out_r <= 1'b0;
      synth_reload_r <= 1'b0;
      tx_en_r <= 1'b0;
    end else begin
      if (tick_r)
        blink_r <= !blink_r;
      if (tick_r)
        alt_cnt_r <= (alt_cnt_r + 4'h1 >= ALT_TICKS) ? 4'h0 : alt_cnt_r + 4'h1;
      if (tick_r && alt_cnt_r + 4'h1 >= ALT_TICKS)
        alt_hi_r <= !alt_hi_r;
      half_cnt_r <= (half_cnt_r + 32'h1 >= half) ? 32'h0 : half_cnt_r + 32'h1;
      if (!(alt || (beep && blink_r)))
        tone_out_r <= 1'b0;
      else if (half_cnt_r + 32'h1 >= half)
        tone_out_r <= !tone_out_r;
      synth_reload_r <= 1'b0;
      if (locked || !rx)
        rl_cnt_r <= 4'h0;
      else if (tick_r) begin
        rl_cnt_r <= (rl_cnt_r + 4'h1 >= RELOAD_TICKS) ? 4'h0 : rl_cnt_r + 4'h1;
        synth_reload_r <= rl_cnt_r + 4'h1 >= RELOAD_TICKS;
      end
      tx_en_r <= st_r == ST_TX && locked;
    end
  end

  // display: channel digits plus timed status glyphs
  reg [6:0] prev_r;
  reg [3:0] gl_cnt_r;
  reg pend_prio_r, scan_prev_r;
  wire pfix = ctrl_r[`RSL_B_PFIX];
  wire [2:0] prio_gl = shown == p1 ? `RSL_GL_FIRST : `RSL_GL_SECOND;
  wire is_prio = pfix && (shown == p1 || shown == p2);
  wire [6:0] num = shown + 7'd1;
  wire [6:0] tens = num / 7'd10;
  wire [6:0] ones = num % 7'd10;
  wire show_ev = shown != prev_r || (scan_prev_r && !scan_on_r) || pwr_up_r;
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      prev_r <= 7'h00;
      gl_cnt_r <= 4'h0;
      pend_prio_r <= 1'b0;
      scan_prev_r <= 1'b0;
      aux_pwr_r <= 1'b0;
      disp_glyph_r <= `RSL_GL_NONE;
      disp_tens_r <= 4'h0;
      disp_ones_r <= 4'h1;
      disp_on_r <= 1'b1;
      tune_chan_r <= 7'h00;
      audio_mute_r <= 1'b1;
      coded_sq_defeat_r <= 1'b0;
      scan_active_r <= 1'b0;
    end else begin
      prev_r <= shown;
      scan_prev_r <= scan_on_r;
      if (rx && rise[I_AUX])
        aux_pwr_r <= !aux_pwr_r;
      if (tick_r && gl_cnt_r != 4'h0)
        gl_cnt_r <= gl_cnt_r - 4'h1;
      if (rx && rise[I_SCAN]) begin
        disp_glyph_r <= scan_on_r ? `RSL_GL_NONE : `RSL_GL_SCAN;
        gl_cnt_r <= FLASH_TICKS;
      end else if (rx && rise[I_LKSW]) begin
        disp_glyph_r <= (!lk_r[shown] && can_lock && (!scan_on_r || listen_r)) ?
                        `RSL_GL_SKIP : `RSL_GL_NONE;
        gl_cnt_r <= FLASH_TICKS;
        pend_prio_r <= 1'b0;
      end else if (rx && rise[I_AUX]) begin
        disp_glyph_r <= aux_pwr_r ? `RSL_GL_NONE : `RSL_GL_ACC;
        gl_cnt_r <= FLASH_TICKS;
      end else if (show_ev) begin
        disp_glyph_r <= lk_r[shown] ? `RSL_GL_SKIP : (is_prio ? prio_gl : `RSL_GL_NONE);
        pend_prio_r <= lk_r[shown] && is_prio;
        gl_cnt_r <= FLASH_TICKS;
      end else if (gl_cnt_r == 4'h0 && pend_prio_r) begin
        disp_glyph_r <= prio_gl;
        pend_prio_r <= 1'b0;
        gl_cnt_r <= FLASH_TICKS;
      end else if (gl_cnt_r == 4'h0)
        disp_glyph_r <= (scan_on_r && !listen_r && rx) ? `RSL_GL_SCAN : `RSL_GL_NONE;
      disp_tens_r <= tens[3:0];
      disp_ones_r <= ones[3:0];
      disp_on_r <= !(beep || alt) || blink_r;
      tune_chan_r <= rx ? (scan_on_r ? scan_ch_r : sel_r) : tx_ch_r;
      audio_mute_r <= !(carrier && !hold_r) || !rx;
      // search mode does its own monitoring, so off-hook leaves coded squelch on
      coded_sq_defeat_r <= s2_r[I_MON] || (s2_r[I_HOOK] && !open_en);
      scan_active_r <= scan_on_r;
    end
  end

  // register read port, data one cycle after the strobe
  always @(posedge mclk or negedge resetn) begin
    if (!resetn)
      reg_rdata_r <= 32'h0;
    else if (reg_rd) begin
      case (reg_addr)
        `RSL_A_CTRL: reg_rdata_r <= {24'h0, ctrl_r};
        `RSL_A_SAVED: reg_rdata_r <= {25'h0, saved_r};
        `RSL_A_STAT: reg_rdata_r <= {8'h0, locked, aux_pwr_r, listen_r, scan_on_r,
                                     st_r, tx_ch_r, 1'b0, sel_r};
        `RSL_A_TOUT: reg_rdata_r <= {16'h0, tout_r};
        `RSL_A_PRIO: reg_rdata_r <= {16'h0, prio_r};
        default: begin
          if (reg_addr[7:4] == `RSL_G_DLK)
            reg_rdata_r <= dlk_r[32*wsel +: 32];
          else if (reg_addr[7:4] == `RSL_G_RXO)
            reg_rdata_r <= rxo_r[32*wsel +: 32];
          else if (reg_addr[7:4] == `RSL_G_LK)
            reg_rdata_r <= lk_r[32*wsel +: 32];
          else
            reg_rdata_r <= 32'h0;
        end
      endcase
    end else
      reg_rdata_r <= 32'h0;
  end
endmodule // rsl_ctrl

// ---- rsl_ctrl_assertions.sv ----
// concurrent checks on the ports of the scan, lockout and display controller
// assumes rsl_ctrl with a shortened TICK_CYC handed on through the bind
`include "rsl_regs.vh"
module rsl_ctrl_checker #(
  parameter TICK_CYC = 20
) (
  input logic mclk,
  input logic resetn,
  input logic ptt_in,
  input logic synth_lock_in,
  input logic tx_en_r,
  input logic synth_reload_r,
  input logic [3:0] disp_tens_r,
  input logic [3:0] disp_ones_r,
  input logic [2:0] disp_glyph_r,
  input logic [6:0] tune_chan_r,
  input logic aux_pwr_r,
  input logic scan_active_r
);
  localparam int GAP = 10 * TICK_CYC - 1;
  logic [15:0] gap_r;
  logic seen_r;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // cycles since the last reload, saturating so a long locked spell cannot wrap
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      gap_r <= 16'h0;
      seen_r <= 1'b0;
    end else if (synth_reload_r) begin
      gap_r <= 16'h0;
      seen_r <= 1'b1;
    end else if (gap_r != 16'hffff) begin
      gap_r <= gap_r + 16'h1;
    end
  end
  property p_reload_space;
    synth_reload_r && seen_r |-> gap_r >= GAP;
  endproperty
  a_reload_space: assert property (p_reload_space) else $error("reload pulses too close");
  property p_reload_rx;
    synth_reload_r |-> !tx_en_r;
  endproperty
  a_reload_rx: assert property (p_reload_rx) else $error("reload while transmitting");
  property p_reload_locked;
    synth_lock_in [*6] |-> !synth_reload_r;
  endproperty
  a_reload_locked: assert property (p_reload_locked) else $error("reload while locked");
  property p_tx_ptt;
    !ptt_in [*6] |-> !tx_en_r;
  endproperty
  a_tx_ptt: assert property (p_tx_ptt) else $error("transmitter on without push-to-talk");
  property p_tx_lock;
    !synth_lock_in [*6] |-> !tx_en_r;
  endproperty
  a_tx_lock: assert property (p_tx_lock) else $error("transmitter on while unlocked");
  property p_bcd;
    disp_tens_r <= 4'h9 && disp_ones_r <= 4'h9;
  endproperty
  a_bcd: assert property (p_bcd) else $error("display digit out of range");
  property p_tune;
    tune_chan_r < `RSL_CH_EXP;
  endproperty
  a_tune: assert property (p_tune) else $error("tuned channel out of range");
  property p_aux_glyph;
    $rose(aux_pwr_r) |-> ##[0:3] disp_glyph_r == `RSL_GL_ACC;
  endproperty
  a_aux_glyph: assert property (p_aux_glyph) else $error("accessory marker missing");
  property p_scan_glyph;
    $rose(scan_active_r) |-> ##[0:3] disp_glyph_r == `RSL_GL_SCAN;
  endproperty
  a_scan_glyph: assert property (p_scan_glyph) else $error("scan marker missing");
  c_tx: cover property ($rose(tx_en_r));
  c_reload: cover property (synth_reload_r && seen_r);
  c_aux: cover property ($rose(aux_pwr_r));
endmodule // rsl_ctrl_checker
bind rsl_ctrl rsl_ctrl_checker #(.TICK_CYC(TICK_CYC)) u_chk (.mclk(mclk), .resetn(resetn), .ptt_in(ptt_in),
  .synth_lock_in(synth_lock_in), .tx_en_r(tx_en_r), .synth_reload_r(synth_reload_r), .disp_tens_r(disp_tens_r),
  .disp_ones_r(disp_ones_r), .disp_glyph_r(disp_glyph_r), .tune_chan_r(tune_chan_r), .aux_pwr_r(aux_pwr_r),
  .scan_active_r(scan_active_r));

// ---- test_radio_scan_lockout_display_ctrl.sv ----
// self-checking bench for the scan, lockout and display controller
// assumes a 20-cycle tick and short tone halves so tick-based counts stay small
`include "rsl_regs.vh"
module test_radio_scan_lockout_display_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e;} rsl_row_t;
  rsl_row_t rows [6] = '{'{8'h00, 1'b0, 32'h0, 32'h0}, '{8'h10, 1'b0, 32'h0, 32'h258},
    '{8'h14, 1'b0, 32'h0, 32'h7f7f}, '{8'h18, 1'b0, 32'h0, 32'h0},
    '{8'h08, 1'b1, 32'h13, 32'h13}, '{8'h08, 1'b1, 32'hff, 32'h7f}};
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic ptt = 1'b0;
  logic hook = 1'b0;
  logic carrier = 1'b0;
  logic lock = 1'b1;
  logic monitor = 1'b0;
  logic [3:0] sw = 4'h0; // scan, lockout, aux, step
  wire [31:0] reg_rdata_r;
  wire tx_en_r, tone_out_r, disp_on_r, synth_reload_r, audio_mute_r, coded_sq_defeat_r, aux_pwr_r, scan_active_r;
  wire [3:0] disp_tens_r, disp_ones_r;
  wire [2:0] disp_glyph_r;
  wire [6:0] tune_chan_r;
  logic [31:0] v, bit_x;
  logic hit, a, b, c;
  int d;
  int miscompares = 0;
  int check_count = 0;
  always #2 mclk = ~mclk;
  rsl_ctrl #(.TICK_CYC(20), .LO_HALF(5), .HI_HALF(4)) dut (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .ptt_in(ptt),
    .hook_off_in(hook), .carrier_in(carrier), .synth_lock_in(lock), .scan_sw_in(sw[0]), .lockout_sw_in(sw[1]),
    .aux_sw_in(sw[2]), .chan_step_in(sw[3]), .monitor_sw_in(monitor), .tx_en_r(tx_en_r), .tone_out_r(tone_out_r),
    .disp_tens_r(disp_tens_r), .disp_ones_r(disp_ones_r), .disp_glyph_r(disp_glyph_r), .disp_on_r(disp_on_r),
    .synth_reload_r(synth_reload_r), .tune_chan_r(tune_chan_r), .audio_mute_r(audio_mute_r),
    .coded_sq_defeat_r(coded_sq_defeat_r), .aux_pwr_r(aux_pwr_r), .scan_active_r(scan_active_r));
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
    @(posedge mclk);
    reg_addr <= ad;
    reg_wdata <= dt;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // data is sampled at the edge that closes the answer cycle
  task automatic rd(input logic [7:0] ad, output logic [31:0] dt);
    @(posedge mclk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    dt = reg_rdata_r;
  endtask
  task automatic pwr(input logic [31:0] s);
    wr(8'h08, s);
    wr(8'h04, 32'h1);
    tick(4);
  endtask
  // held long enough to pass the two-stage synchroniser
  task automatic press(input int k);
    sw[k] <= 1'b1;
    tick(4);
    sw[k] <= 1'b0;
    tick(4);
  endtask
  task automatic wait_tx(input logic e);
    for (int i = 0; i < 400 && tx_en_r !== e; i++) @(posedge mclk);
    chk(tx_en_r, e);
  endtask
  // a: transmitter seen on, b: display dark seen, c: tone toggled, d: reload pulses
  task automatic watch(input int n);
    logic t0;
    a = 1'b0;
    b = 1'b0;
    c = 1'b0;
    d = 0;
    t0 = tone_out_r;
    repeat (n) begin
      @(posedge mclk);
      a |= (tx_en_r === 1'b1);
      b |= (disp_on_r === 1'b0);
      c |= (tone_out_r !== t0);
      d += (synth_reload_r === 1'b1);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    tick(20000);
    miscompares++;
    conclude();
  end
  initial begin
    tick(3);
    resetn <= 1'b1;
    tick(2);
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rd(rows[i].a, v);
      chk(v, rows[i].e);
    end
    wr(8'h20, 32'h8);
    wr(8'h40, 32'h88);
    pwr(32'd5);
    chk({disp_tens_r, disp_ones_r}, 8'h06);
    chk(tune_chan_r, 7'd5);
    rd(8'h40, v);
    chk(v, 32'h8);
    pwr(32'd25);
    chk({disp_tens_r, disp_ones_r}, 8'h01);
    wr(8'h00, 32'h8);
    pwr(32'd25);
    chk({disp_tens_r, disp_ones_r}, 8'h26);
    wr(8'h00, 32'h4);
    wr(8'h40, 32'h88);
    pwr(32'd5);
    rd(8'h40, v);
    chk(v, 32'h88);
    wr(8'h00, 32'h0);
    press(1);
    rd(8'h40, v);
    chk(v, 32'ha8);
    chk(disp_glyph_r, `RSL_GL_SKIP);
    tick(250);
    press(1);
    rd(8'h40, v);
    chk(v, 32'h88);
    chk(disp_glyph_r, `RSL_GL_NONE);
    pwr(32'd3);
    chk(disp_glyph_r, `RSL_GL_SKIP);
    press(1);
    rd(8'h40, v);
    chk(v, 32'h0);
    wr(8'h40, 32'hffff7);
    press(1);
    rd(8'h40, v);
    chk(v, 32'hffff7);
    wr(8'h40, 32'h10);
    wr(8'h00, 32'h1);
    carrier <= 1'b1;
    ptt <= 1'b1;
    hit = 1'b0;
    // drop carrier once the search reaches channel index 5
    for (int i = 0; i < 400 && tx_en_r !== 1'b1; i++) begin
      @(posedge mclk);
      if (tune_chan_r === 7'd4) hit = 1'b1;
      if (tune_chan_r === 7'd5) carrier <= 1'b0;
    end
    chk(tune_chan_r, 7'd5);
    chk(hit, 1'b0);
    ptt <= 1'b0;
    wait_tx(1'b0);
    wr(8'h00, 32'h2);
    carrier <= 1'b1;
    ptt <= 1'b1;
    watch(300);
    chk({a, b, c}, 3'b011);
    ptt <= 1'b0;
    carrier <= 1'b0;
    wr(8'h00, 32'h0);
    wr(8'h30, 32'h8);
    ptt <= 1'b1;
    watch(300);
    chk({a, b, c}, 3'b011);
    ptt <= 1'b0;
    wr(8'h30, 32'h0);
    wr(8'h10, 32'h2);
    ptt <= 1'b1;
    wait_tx(1'b1);
    tick(150);
    watch(200);
    chk({a, b, c}, 3'b011);
    ptt <= 1'b0;
    tick(10);
    watch(100);
    chk(c, 1'b0);
    wr(8'h10, 32'h258);
    ptt <= 1'b1;
    wait_tx(1'b1);
    lock <= 1'b0;
    tick(10);
    chk(tx_en_r, 1'b0);
    watch(300);
    chk({b, c}, 2'b11);
    ptt <= 1'b0;
    watch(450);
    chk(d >= 2 && d <= 3, 1'b1);
    lock <= 1'b1;
    wr(8'h14, 32'h7f05);
    wr(8'h00, 32'h10);
    press(3);
    chk(disp_glyph_r, `RSL_GL_SKIP);
    press(3);
    chk(disp_glyph_r, `RSL_GL_FIRST);
    wr(8'h00, 32'h1);
    press(2);
    chk({aux_pwr_r, disp_glyph_r}, {1'b1, `RSL_GL_ACC});
    press(0);
    chk({scan_active_r, disp_glyph_r}, {1'b1, `RSL_GL_SCAN});
    hook <= 1'b1;
    tick(60);
    chk({scan_active_r, coded_sq_defeat_r}, 2'b10);
    monitor <= 1'b1;
    tick(10);
    chk(coded_sq_defeat_r, 1'b1);
    monitor <= 1'b0;
    hook <= 1'b0;
    press(1);
    rd(8'h40, v);
    chk(v, 32'h10);
    carrier <= 1'b1;
    tick(60);
    bit_x = 32'h10 | (32'h1 << tune_chan_r);
    chk(audio_mute_r, 1'b0);
    press(1);
    chk(audio_mute_r, 1'b1);
    rd(8'h40, v);
    chk(v, bit_x);
    carrier <= 1'b0;
    press(0);
    conclude();
  end
endmodule // test_radio_scan_lockout_display_ctrl
